// ### src/frt_cfg.svh
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH

// Register byte offsets on the AXI4-Lite bus.
`define FRT_OFS_CTRL     8'h00
`define FRT_OFS_COUNT    8'h04
`define FRT_OFS_EDGE     8'h08
`define FRT_OFS_XFER     8'h0c
`define FRT_OFS_STATUS   8'h10
`define FRT_OFS_CLEAR    8'h14
`define FRT_OFS_ENABLE   8'h18
`define FRT_OFS_CAP0     8'h20
`define FRT_OFS_CAP3     8'h2c

// Fields of counter_control_status.
`define FRT_DIV_LSB      0
`define FRT_DIV_MSB      2
`define FRT_EXT_BIT      3
`define FRT_CLR_BIT      4
`define FRT_RUN_BIT      5
`define FRT_OVF_BIT      6
`define FRT_OVIE_BIT     7

// Event bit positions in status, clear, enable and transfer select.
`define FRT_EV_OVF       0
`define FRT_EV_CAP0      1

`define FRT_COUNT_RST    16'h0000
`define FRT_COUNT_MAX    16'hffff
`define FRT_OVF_IRQ_NUM  5'h13
`define FRT_RESP_OKAY    2'b00
`define FRT_RESP_SLVERR  2'b10

`endif

// ### src/frt_pkg.sv
package frt_pkg;

  typedef enum logic [1:0] {
    FRT_EDGE_NONE = 2'b00,
    FRT_EDGE_RISE = 2'b01,
    FRT_EDGE_FALL = 2'b10,
    FRT_EDGE_BOTH = 2'b11
  } frt_edge_e;

  typedef struct packed {
    logic [15:0]      count;
    logic [6:0]       pre;
    logic [2:0]       div_sel;
    logic             ext_sel;
    logic             run;
    logic [4:0]       status;
    logic [4:0]       enable;
    logic [4:0]       xfer_sel;
    logic [3:0][1:0]  edge_cfg;
    logic [3:0][15:0] cap;
    logic             ext_q;
    logic [3:0]       cap_q;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } frt_state_s;

endpackage : frt_pkg

// ### src/frt_timer.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Summary of operation
// R1 - Time base is a 16-bit up-counter stepping once per count clock tick.
// R2 - Count clock is one of eight machine clock fractions or the external pin.
// R3 - The divide field in the control/status register picks the machine clock ratio.
// R4 - Counter overflow may raise an interrupt when overflow interrupt is enabled.
// R5 - Overflow and capture events may start the auto transfer service instead.
// R6 - Reset and software count clear bit both force the counter to zero.
// R7 - Present count is fed continuously to all capture channels.
// R8 - A selected edge stores the present count into that channel's capture register.
// R9 - Each channel triggers on rising, falling or both edges.
// R10 - A detected capture edge can raise an interrupt request.
// R11 - Four capture channels, pin plus data register, in two units of two.
// R12 - Reading the counter value register returns the present count.
// R13 - Software may load the counter, effective only while counting is stopped.
// R14 - Control/status holds divide, clear, run, overflow flag and overflow enable.
// R15 - Overflow interrupt is request number 19.
// R16 - Overflow flag sets on wrap from all ones and stays until cleared.
// R17 - Each channel has a sticky capture flag, enabled to interrupt, software cleared.
`include "frt_cfg.svh"

module frt_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // External pins
  input  wire logic        free_run_ext_clock_pin,
  input  wire logic [3:0]  capture_pin,
  // Time base and events
  output logic [15:0]      timer_count,
  output logic             irq,
  output logic             ovf_irq,
  output logic [4:0]       ovf_irq_num,
  output logic [3:0]       cap_irq,
  output logic [4:0]       auto_transfer_req
);

  frt_pkg::frt_state_s s;
  frt_pkg::frt_state_s n;

  logic        tick;
  logic        aw_take;
  logic        w_take;
  logic        have_aw;
  logic        have_w;
  logic        wr_fire;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [31:0] wv;
  logic [3:0]  hit;
  logic [4:0]  sets;
  logic [4:0]  clrs;
  logic        wr_ok;
  logic [4:0]  pend;

  function automatic logic [31:0] frt_merge(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : frt_merge

  function automatic logic frt_edge_hit(input logic [1:0] cfg,
                                        input logic       prev,
                                        input logic       cur);
    return (cfg[0] & cur & ~prev) | (cfg[1] & ~cur & prev);
  endfunction : frt_edge_hit

  function automatic logic [31:0] frt_ctrl_word(input frt_pkg::frt_state_s x);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`FRT_DIV_MSB:`FRT_DIV_LSB] = x.div_sel;
    r[`FRT_EXT_BIT] = x.ext_sel;
    r[`FRT_RUN_BIT] = x.run;
    r[`FRT_OVF_BIT] = x.status[`FRT_EV_OVF];
    r[`FRT_OVIE_BIT] = x.enable[`FRT_EV_OVF];
    return r;
  endfunction : frt_ctrl_word

  // A write is only taken while no response is waiting, so one write is in flight.
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready  = ~s.w_got & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;

  assign timer_count = s.count; // R7
  // Events routed to the transfer service do not also interrupt.
  assign pend              = s.status & s.enable;
  assign auto_transfer_req = pend & s.xfer_sel; // R5
  assign ovf_irq           = pend[`FRT_EV_OVF] & ~s.xfer_sel[`FRT_EV_OVF]; // R4
  assign ovf_irq_num       = `FRT_OVF_IRQ_NUM; // R15
  assign cap_irq           = pend[4:1] & ~s.xfer_sel[4:1]; // R10 R17
  assign irq               = |(pend & ~s.xfer_sel);

  always_comb
  begin
    n       = s;
    sets    = 5'h00;
    clrs    = 5'h00;
    wr_ok   = 1'b1;
    wv      = 32'h0000_0000;
    aw_take = awvalid & awready;
    w_take  = wvalid & wready;
    have_aw = s.aw_got | aw_take;
    have_w  = s.w_got | w_take;
    wa      = s.aw_got ? s.aw_addr : awaddr;
    wd      = s.w_got ? s.wdata : wdata;
    ws      = s.w_got ? s.wstrb : wstrb;
    wr_fire = have_aw & have_w & ~s.bvalid;

    // The external pin is sampled each machine clock, so it must stay at or below half its rate.
    n.ext_q = free_run_ext_clock_pin;
    n.pre   = s.pre + 7'h01;
    if (s.ext_sel)
    begin
      tick = free_run_ext_clock_pin & ~s.ext_q; // R2
    end
    else
    begin
      tick = (s.pre & ((7'h01 << s.div_sel) - 7'h01)) == ((7'h01 << s.div_sel) - 7'h01); // R3
    end

    if (tick && s.run)
    begin
      n.count = s.count + 16'h0001; // R1
      if (s.count == `FRT_COUNT_MAX)
      begin
        sets[`FRT_EV_OVF] = 1'b1; // R16
      end
    end

    n.cap_q = capture_pin;
    for (int c = 0; c < 4; c++)
    begin
      hit[c] = frt_edge_hit(s.edge_cfg[c], s.cap_q[c], capture_pin[c]); // R9
      if (hit[c])
      begin
        n.cap[c] = s.count; // R8 R11
        sets[`FRT_EV_CAP0 + c] = 1'b1; // R17
      end
    end

    if (aw_take)
    begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (w_take)
    begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end

    if (wr_fire)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      if (wa == `FRT_OFS_CTRL)
      begin
        wv = frt_merge(frt_ctrl_word(s), wd, ws);
        n.div_sel = wv[`FRT_DIV_MSB:`FRT_DIV_LSB];
        n.ext_sel = wv[`FRT_EXT_BIT];
        n.run     = wv[`FRT_RUN_BIT];
        n.enable[`FRT_EV_OVF] = wv[`FRT_OVIE_BIT]; // R14
        clrs[`FRT_EV_OVF] = ~wv[`FRT_OVF_BIT];
        if (wv[`FRT_CLR_BIT])
        begin
          n.count = `FRT_COUNT_RST; // R6
        end
      end
      else if (wa == `FRT_OFS_COUNT)
      begin
        wv = frt_merge({16'h0000, s.count}, wd, ws);
        if (!s.run)
        begin
          n.count = wv[15:0]; // R13
        end
      end
      else if (wa == `FRT_OFS_EDGE)
      begin
        wv = frt_merge({24'h000000, s.edge_cfg}, wd, ws);
        n.edge_cfg = wv[7:0];
      end
      else if (wa == `FRT_OFS_XFER)
      begin
        wv = frt_merge({27'h0000000, s.xfer_sel}, wd, ws);
        n.xfer_sel = wv[4:0];
      end
      else if (wa == `FRT_OFS_CLEAR)
      begin
        clrs = wd[4:0] & {5{ws[0]}};
      end
      else if (wa == `FRT_OFS_ENABLE)
      begin
        wv = frt_merge({27'h0000000, s.enable}, wd, ws);
        n.enable = wv[4:0];
      end
      else if (wa == `FRT_OFS_STATUS)
      begin
        wr_ok = 1'b1;
      end
      else
      begin
        wr_ok = 1'b0;
      end
      n.bresp = wr_ok ? `FRT_RESP_OKAY : `FRT_RESP_SLVERR;
    end
    else if (s.bvalid && bready)
    begin
      n.bvalid = 1'b0;
    end

    // A clear never hides an event that lands in the same cycle.
    n.status = (s.status & ~clrs) | sets;

    if (arvalid && arready)
    begin
      n.rvalid = 1'b1;
      n.rresp  = `FRT_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      if (araddr == `FRT_OFS_CTRL)
      begin
        n.rdata = frt_ctrl_word(s); // R14
      end
      else if (araddr == `FRT_OFS_COUNT)
      begin
        n.rdata = {16'h0000, s.count}; // R12
      end
      else if (araddr == `FRT_OFS_EDGE)
      begin
        n.rdata = {24'h000000, s.edge_cfg};
      end
      else if (araddr == `FRT_OFS_XFER)
      begin
        n.rdata = {27'h0000000, s.xfer_sel};
      end
      else if (araddr == `FRT_OFS_STATUS)
      begin
        n.rdata = {27'h0000000, s.status};
      end
      else if (araddr == `FRT_OFS_CLEAR)
      begin
        n.rdata = 32'h0000_0000;
      end
      else if (araddr == `FRT_OFS_ENABLE)
      begin
        n.rdata = {27'h0000000, s.enable};
      end
      else if (araddr >= `FRT_OFS_CAP0 && araddr <= `FRT_OFS_CAP3 && araddr[1:0] == 2'b00)
      begin
        n.rdata = {16'h0000, s.cap[araddr[3:2]]};
      end
      else
      begin
        n.rresp = `FRT_RESP_SLVERR;
      end
    end
    else if (s.rvalid && rready)
    begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0; // R6
    end
    else
    begin
      s <= n;
    end
  end

  AST_COUNT_STEP: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (tick && s.run && !wr_fire) |=> (s.count == $past(s.count) + 16'h0001))
    else $error("Counter did not step on a count clock tick.");

  AST_DIV_RATIO: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    (!s.ext_sel && s.div_sel == 3'h1 && s.pre[0] == 1'b0) |-> !tick)
    else $error("Divide by two ticked on an even prescaler phase.");

  AST_EXT_TICK: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (s.ext_sel && !s.ext_q && free_run_ext_clock_pin) |-> tick)
    else $error("External clock rising edge produced no tick.");

  AST_OVF_SET: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    (tick && s.run && s.count == `FRT_COUNT_MAX) |=> s.status[`FRT_EV_OVF])
    else $error("Overflow flag not set on wrap.");

  AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    (wr_fire && wa == `FRT_OFS_CTRL && ws[0] && wd[`FRT_CLR_BIT]) |=> s.count == 16'h0000)
    else $error("Software clear left the counter nonzero.");

  AST_LOAD_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    (wr_fire && wa == `FRT_OFS_COUNT && s.run && !tick) |=> $stable(s.count))
    else $error("Counter load took effect while running.");

  AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    hit[0] |=> (s.cap[0] == $past(s.count) && s.status[`FRT_EV_CAP0]))
    else $error("Capture channel 0 did not store the count.");

  AST_RISE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (s.edge_cfg[0] == 2'b01 && s.cap_q[0] && !capture_pin[0]) |-> !hit[0])
    else $error("Rising-only channel fired on a falling edge.");

  AST_OVF_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    (sets[`FRT_EV_OVF] && s.enable[`FRT_EV_OVF] && !s.xfer_sel[`FRT_EV_OVF])
      |=> (ovf_irq && irq) [*2])
    else $error("Overflow interrupt not raised and held.");

  AST_XFER_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    auto_transfer_req[`FRT_EV_CAP0] |-> !cap_irq[0])
    else $error("Transfer-routed capture also raised an interrupt.");

  AST_OVF_STICKY: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    (s.status[`FRT_EV_OVF] && !(wr_fire && (wa == `FRT_OFS_CTRL || wa == `FRT_OFS_CLEAR)))
      |=> s.status[`FRT_EV_OVF])
    else $error("Overflow flag dropped without a software clear.");

  AST_WRAP_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (tick && s.run && !wr_fire && s.count == `FRT_COUNT_MAX)
      |=> (s.count == `FRT_COUNT_RST))
    else $error("Counter did not wrap from all ones to zero.");

  AST_FALL_ONLY: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (s.edge_cfg[1] == 2'b10 && !s.cap_q[1] && capture_pin[1]) |-> !hit[1])
    else $error("Falling-only channel fired on a rising edge.");

  AST_LOAD_TAKEN: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    (wr_fire && wa == `FRT_OFS_COUNT && !s.run && ws[1:0] == 2'b11)
      |=> (s.count == $past(wd[15:0])))
    else $error("Counter load while stopped did not take effect.");

  AST_READ_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    (arvalid && arready && araddr == `FRT_OFS_COUNT)
      |=> (rdata == {16'h0000, $past(s.count)}))
    else $error("Counter read returned a stale value.");

endmodule : frt_timer

// ### tb/frt_pin_src.sv
`timescale 1ns/1ns

module frt_pin_src (
  // Clock
  input  wire logic       aclk,
  // Pins
  output logic            ext_clk,
  output logic [3:0]      cap
);
  initial
  begin
    ext_clk = 1'h0;
    cap     = 4'h0;
  end

  // One count clock pulse is one cycle high then one low, so every rise is seen.
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      ext_clk <= 1'h1;
      @(posedge aclk);
      ext_clk <= 1'h0;
    end
    repeat (2) @(posedge aclk);
  endtask : ext_pulses

  // Levels are held long enough for the edge and its flag to settle.
  task automatic drive_cap(input logic [3:0] v);
    @(posedge aclk);
    cap <= v;
    repeat (3) @(posedge aclk);
  endtask : drive_cap
endmodule : frt_pin_src

// ### tb/frt_timer_test.sv
`timescale 1ns/1ns

module frt_timer_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, ovf_irq, ext_clk;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb, cap_irq, cap_pin;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [15:0] timer_count, t0;
  logic [4:0]  ovf_irq_num, auto_transfer_req;
  int          n_mismatch, comparisons, cyc;

  frt_timer dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .free_run_ext_clock_pin(ext_clk), .capture_pin(cap_pin), .timer_count,
    .irq, .ovf_irq, .ovf_irq_num, .cap_irq, .auto_transfer_req
  );

  frt_pin_src src (.aclk, .ext_clk, .cap(cap_pin));

  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("TB: mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready is sampled at the falling edge so the decision never races the rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, sb;
    ta = 1'h0;
    tw = 1'h0;
    sb = 1'h0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge aclk);
      awvalid <= !ta;
      wvalid  <= !tw;
    end
    bready <= 1'h1;
    while (!sb)
    begin
      @(negedge aclk);
      sb = bvalid;
      bs = bresp;
      @(posedge aclk);
    end
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic sa, sr;
    sa = 1'h0;
    sr = 1'h0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    while (!sa)
    begin
      @(negedge aclk);
      sa = arready;
      @(posedge aclk);
    end
    arvalid <= 1'h0;
    rready  <= 1'h1;
    while (!sr)
    begin
      @(negedge aclk);
      sr  = rvalid;
      rdv = rdata;
      rs  = rresp;
      @(posedge aclk);
    end
    rready <= 1'h0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rc

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  initial
  begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata  = 32'h0;
    wstrb  = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h10, 32'h0);
    wr(8'h04, 32'h0000fffd);
    rc(8'h04, 32'h0000fffd);
    wr(8'h18, 32'h00000001);
    rc(8'h00, 32'h00000080);
    wr(8'h00, 32'h000000a8);
    src.ext_pulses(2);
    rc(8'h04, 32'h0000ffff);
    @(negedge aclk);
    chk(irq, 1'h0);
    // A load while running must be dropped; the next wrap proves it.
    wr(8'h04, 32'h00001234);
    src.ext_pulses(1);
    rc(8'h04, 32'h0);
    rc(8'h00, 32'h000000e8);
    rc(8'h10, 32'h1);
    @(negedge aclk);
    chk(irq, 1'h1);
    chk(ovf_irq, 1'h1);
    chk(ovf_irq_num, 5'h13);
    chk(timer_count, 16'h0);
    src.ext_pulses(1);
    @(negedge aclk);
    chk(timer_count, 16'h1);
    wr(8'h00, 32'h000000f8);
    rc(8'h04, 32'h0);
    rc(8'h10, 32'h1);
    wr(8'h14, 32'h1);
    @(negedge aclk);
    chk(irq, 1'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h00000abc);
    wr(8'h08, 32'h00000039);
    wr(8'h18, 32'h0000001e);
    wr(8'h0c, 32'h00000002);
    src.drive_cap(4'hf);
    rc(8'h10, 32'h0000000a);
    @(negedge aclk);
    chk(cap_irq, 4'h4);
    chk(auto_transfer_req, 5'h02);
    chk(irq, 1'h1);
    wr(8'h04, 32'h00000def);
    src.drive_cap(4'h0);
    rc(8'h10, 32'h0000000e);
    rc(8'h20, 32'h00000abc);
    rc(8'h24, 32'h00000def);
    rc(8'h28, 32'h00000def);
    rc(8'h2c, 32'h0);
    wr(8'h14, 32'h0000001e);
    rc(8'h10, 32'h0);
    @(negedge aclk);
    chk(cap_irq, 4'h0);
    chk(irq, 1'h0);
    chk(auto_transfer_req, 5'h00);
    rd(8'h40);
    chk(rs, 2'h2);
    wr(8'h40, 32'h1);
    chk(bs, 2'h2);
    // Divide by two: any sixteen machine clocks hold exactly eight count ticks.
    wr(8'h00, 32'h00000021);
    @(negedge aclk);
    t0 = timer_count;
    repeat (16) @(negedge aclk);
    chk(timer_count - t0, 32'h00000008);
    complete_run();
  end
endmodule : frt_timer_test
